/* src/sfd_dev.sv */
/*
 Device end of the serial flash command decoder, plus the pin synchroniser
 shared with the host end.
 Assumes the link pins are asynchronous to clk and the serial clock is at
 most about a tenth of clk; read data arrives combinationally on rd_data.
*/
// Overview of operation
// - every bus cycle is eight serial clocks
// - program and erase need the write latch set
// - chip select falling edge starts a new opcode
// - input sampled on serial clock rise, MSB first
// - host frames instruction; deselect triggers execution
// - read types stream output until deselect
// - opcode, address and data go MSB first
// - read opcodes 03, 0B, 05, 90, AB
// - write opcodes 20, 52, D8, 60, C7, 02, AF
// - opcodes 50, 01, 06, 04 take no address
// - three address bytes, high byte first
// - fast read waits one dummy byte
// - status write applies only right after unlock
// - address bit zero picks manufacturer or device code
`timescale 1ns/1ps
`include "sfd_map.svh"

////////////////////////////////////////////////////////////////////////////
/* Three-stage synchroniser; the output follows once stages two and three
   agree. */
module sfd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         q <= INIT;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q <= (agree & s3_reg) | (~agree & q);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module sfd_dev #(
   parameter logic [7:0] MAN_ID = `SFD_MAN_ID,
   parameter logic [7:0] DEV_ID = `SFD_DEV_ID
) (
   input wire logic clk,
   input wire logic rst,
   sfd_if.dev link,
   input wire logic busy,
   input wire logic [5:0] status_hi,
   input wire logic [7:0] rd_data,
   output logic [23:0] rd_addr,
   output logic op_valid,
   output logic [7:0] op_code,
   output logic [23:0] op_addr,
   output logic [7:0] op_data,
   output logic wel,
   output logic aai_mode
);
   sfd_pkg::sfd_dev_state_t state_reg, state_next;
   logic [2:0] sck_cs_mosi;
   logic sck_d_reg;
   logic cs_d_reg;
   logic [2:0] bit_reg;
   logic [1:0] abyte_reg;
   logic [7:0] sh_reg;
   logic [7:0] cmd_reg;
   logic [23:0] addr_reg;
   logic [7:0] data_reg;
   logic [7:0] out_reg;
   logic load_pend_reg;
   logic unlock_reg;

   sfd_sync #(.W(3), .INIT(3'h2)) pin_sync (
      .clk(clk),
      .rst(rst),
      .d({link.sck, link.cs_n, link.mosi}),
      .q(sck_cs_mosi)
   );

   wire logic sck_q = sck_cs_mosi[2];
   wire logic cs_q = sck_cs_mosi[1];
   wire logic mosi_q = sck_cs_mosi[0];
   wire logic cs_fall = ~cs_q & cs_d_reg;
   wire logic cs_rise = cs_q & ~cs_d_reg;
   wire logic sck_rise = sck_q & ~sck_d_reg & ~cs_q;
   wire logic sck_fall = ~sck_q & sck_d_reg & ~cs_q;
   wire logic byte_done = sck_rise & (bit_reg == `SFD_BIT_LAST);
   wire logic [7:0] in_byte = {sh_reg[6:0], mosi_q};
   wire sfd_pkg::sfd_op_info_t in_info = sfd_pkg::op_info(in_byte);
   wire sfd_pkg::sfd_op_info_t cmd_info = sfd_pkg::op_info(cmd_reg);
   wire logic busy_block = busy & (in_byte != `SFD_OP_STAT_RD);
   wire logic wel_block = in_info.needs_wel & ~wel;
   wire logic op_ok = in_info.known & ~busy_block & ~wel_block;
   wire logic aai_next = (in_byte == `SFD_OP_AAI) & aai_mode;
   wire logic is_id = (cmd_reg == `SFD_OP_ID_A) | (cmd_reg == `SFD_OP_ID_B);
   wire logic is_stat = cmd_reg == `SFD_OP_STAT_RD;
   wire logic exec = cs_rise & (state_reg == sfd_pkg::DEV_DONE);
   wire logic exec_ok = exec & ((cmd_reg != `SFD_OP_STAT_WR) | unlock_reg);
   wire logic is_aai = cmd_reg == `SFD_OP_AAI;
   wire logic aai_top = is_aai & (addr_reg == `SFD_ADDR_TOP);
   wire logic wel_clr = (cmd_reg == `SFD_OP_CLR_WL) | aai_top
      | (cmd_info.needs_wel & ~is_aai);
   wire logic load = sck_fall & load_pend_reg;
   wire logic [7:0] id_byte = addr_reg[0] ? DEV_ID : MAN_ID;
   wire logic [7:0] stat_byte = {status_hi, wel, busy};
   wire logic [7:0] load_byte = is_stat ? stat_byte
      : (is_id ? id_byte : rd_data);

   assign rd_addr = addr_reg;
   assign link.miso = out_reg[7];
   assign link.miso_oe = state_reg == sfd_pkg::DEV_OUT;

   ////////////////////////////////////////////////////////////////////////
   // Instruction sequencer.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sfd_pkg::DEV_IDLE: state_next = sfd_pkg::DEV_IDLE;
         sfd_pkg::DEV_OPC: begin
            if (byte_done) begin
               if (!op_ok) begin
                  state_next = sfd_pkg::DEV_IGN;
               end else if (in_byte == `SFD_OP_STAT_RD) begin
                  state_next = sfd_pkg::DEV_OUT;
               end else if (aai_next) begin
                  state_next = sfd_pkg::DEV_DIN;
               end else if (in_info.has_addr) begin
                  state_next = sfd_pkg::DEV_ADDR;
               end else if (in_info.has_data) begin
                  state_next = sfd_pkg::DEV_DIN;
               end else begin
                  state_next = sfd_pkg::DEV_DONE;
               end
            end
         end
         sfd_pkg::DEV_ADDR: begin
            if (byte_done && abyte_reg == `SFD_ADDR_LAST) begin
               if (cmd_info.dummy) begin
                  state_next = sfd_pkg::DEV_DUMMY;
               end else if (cmd_info.is_read) begin
                  state_next = sfd_pkg::DEV_OUT;
               end else if (cmd_info.has_data) begin
                  state_next = sfd_pkg::DEV_DIN;
               end else begin
                  state_next = sfd_pkg::DEV_DONE;
               end
            end
         end
         sfd_pkg::DEV_DUMMY: begin
            if (byte_done) begin
               state_next = sfd_pkg::DEV_OUT;
            end
         end
         sfd_pkg::DEV_DIN: begin
            if (byte_done) begin
               state_next = sfd_pkg::DEV_DONE;
            end
         end
         sfd_pkg::DEV_DONE: state_next = sfd_pkg::DEV_DONE;
         sfd_pkg::DEV_OUT: state_next = sfd_pkg::DEV_OUT;
         sfd_pkg::DEV_IGN: state_next = sfd_pkg::DEV_IGN;
         default: state_next = sfd_pkg::DEV_IDLE;
      endcase
      if (cs_rise) begin
         state_next = sfd_pkg::DEV_IDLE;
      end
      if (cs_fall) begin
         state_next = sfd_pkg::DEV_OPC;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= sfd_pkg::DEV_IDLE;
         sck_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         sck_d_reg <= sck_q;
         cs_d_reg <= cs_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input shifting and field capture.
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_reg <= '0;
         abyte_reg <= '0;
         sh_reg <= '0;
         cmd_reg <= '0;
         data_reg <= '0;
      end else if (cs_fall) begin
         bit_reg <= '0;
         abyte_reg <= '0;
      end else if (sck_rise) begin
         bit_reg <= bit_reg + 3'h1;
         sh_reg <= in_byte;
         if (byte_done && state_reg == sfd_pkg::DEV_OPC) begin
            cmd_reg <= in_byte;
         end
         if (byte_done && state_reg == sfd_pkg::DEV_ADDR) begin
            abyte_reg <= abyte_reg + 2'h1;
         end
         if (byte_done && state_reg == sfd_pkg::DEV_DIN) begin
            data_reg <= in_byte;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_reg <= '0;
      end else if (byte_done && state_reg == sfd_pkg::DEV_ADDR) begin
         addr_reg <= {addr_reg[15:0], in_byte};
      end else if ((load && !is_stat) || (exec_ok && is_aai)) begin
         addr_reg <= addr_reg + 24'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output shifting: a byte is loaded at the fall after the last input
   // bit so that its top bit is valid before the host samples it at its next fall.
   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= '0;
         load_pend_reg <= 1'b0;
      end else begin
         if (cs_rise || cs_fall) begin
            load_pend_reg <= 1'b0;
         end else if (byte_done && state_next == sfd_pkg::DEV_OUT) begin
            load_pend_reg <= 1'b1;
         end else if (load) begin
            load_pend_reg <= 1'b0;
         end
         if (load) begin
            out_reg <= load_byte;
         end else if (sck_fall && state_reg == sfd_pkg::DEV_OUT) begin
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Execution at deselect.
   always_ff @(posedge clk) begin
      if (rst) begin
         wel <= 1'b0;
         aai_mode <= 1'b0;
         unlock_reg <= 1'b0;
         op_valid <= 1'b0;
         op_code <= '0;
         op_addr <= '0;
         op_data <= '0;
      end else begin
         op_valid <= exec_ok;
         if (exec_ok) begin
            op_code <= cmd_reg;
            op_addr <= addr_reg;
            op_data <= data_reg;
         end
         if (cs_rise) begin
            unlock_reg <= exec & (cmd_reg == `SFD_OP_UNLOCK);
         end
         if (exec_ok && cmd_reg == `SFD_OP_SET_WL) begin
            wel <= 1'b1;
         end else if (exec_ok && wel_clr) begin
            wel <= 1'b0;
         end
         if (exec_ok && is_aai && !aai_top) begin
            aai_mode <= 1'b1;
         end else if (exec_ok && (cmd_reg == `SFD_OP_CLR_WL || aai_top)) begin
            aai_mode <= 1'b0;
         end
      end
   end
endmodule

/* src/sfd_map.svh */
/*
 Offsets, opcodes, identity values and timing counts of the serial flash
 command decoder and its host end.
 Assumes it is included by bare name from the package and the modules.
*/
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// Opcodes.
`define SFD_OP_READ 8'h03
`define SFD_OP_FAST 8'h0b
`define SFD_OP_STAT_RD 8'h05
`define SFD_OP_ID_A 8'h90
`define SFD_OP_ID_B 8'hab
`define SFD_OP_SECT 8'h20
`define SFD_OP_BLK_A 8'h52
`define SFD_OP_BLK_B 8'hd8
`define SFD_OP_CHIP_A 8'h60
`define SFD_OP_CHIP_B 8'hc7
`define SFD_OP_PROG 8'h02
`define SFD_OP_AAI 8'haf
`define SFD_OP_UNLOCK 8'h50
`define SFD_OP_STAT_WR 8'h01
`define SFD_OP_SET_WL 8'h06
`define SFD_OP_CLR_WL 8'h04

// Framing.
`define SFD_BIT_LAST 3'h7
`define SFD_ADDR_LAST 2'h2
`define SFD_ADDR_TOP 24'hffffff

// Identification bytes; the values are arbitrary.
`define SFD_MAN_ID 8'h5a
`define SFD_DEV_ID 8'h3c

// Host timing: clock cycles per half period of the serial clock, and command FIFO depth.
`define SFD_HALF_DEF 6
`define SFD_HALF_MIN 5
`define SFD_FIFO_DEPTH 8

`endif

/* src/sfd_pkg.sv */
/*
 Types shared by both ends: state enums and the opcode property table.
 Assumes sfd_map.svh is on the include path.
*/
`include "sfd_map.svh"

package sfd_pkg;

   typedef enum logic [7:0] {
      DEV_IDLE = 8'h01,
      DEV_OPC = 8'h02,
      DEV_ADDR = 8'h04,
      DEV_DUMMY = 8'h08,
      DEV_DIN = 8'h10,
      DEV_DONE = 8'h20,
      DEV_OUT = 8'h40,
      DEV_IGN = 8'h80
   } sfd_dev_state_t;

   typedef enum logic [4:0] {
      HST_IDLE = 5'h01,
      HST_LOW = 5'h02,
      HST_HIGH = 5'h04,
      HST_END = 5'h08,
      HST_GAP = 5'h10
   } sfd_host_state_t;

   typedef struct packed {
      logic known;
      logic has_addr;
      logic dummy;
      logic has_data;
      logic is_read;
      logic needs_wel;
   } sfd_op_info_t;

   function automatic sfd_op_info_t op_info(input logic [7:0] op);
      sfd_op_info_t i;
      i = '0;
      i.known = 1'b1;
      case (op)
         `SFD_OP_READ: begin
            i.has_addr = 1'b1;
            i.is_read = 1'b1;
         end
         `SFD_OP_FAST, `SFD_OP_ID_A, `SFD_OP_ID_B: begin
            i.has_addr = 1'b1;
            i.dummy = 1'b1;
            i.is_read = 1'b1;
         end
         `SFD_OP_STAT_RD: i.is_read = 1'b1;
         `SFD_OP_SECT, `SFD_OP_BLK_A, `SFD_OP_BLK_B: begin
            i.has_addr = 1'b1;
            i.needs_wel = 1'b1;
         end
         `SFD_OP_CHIP_A, `SFD_OP_CHIP_B: i.needs_wel = 1'b1;
         `SFD_OP_PROG, `SFD_OP_AAI: begin
            i.has_addr = 1'b1;
            i.has_data = 1'b1;
            i.needs_wel = 1'b1;
         end
         `SFD_OP_STAT_WR: i.has_data = 1'b1;
         `SFD_OP_UNLOCK, `SFD_OP_SET_WL, `SFD_OP_CLR_WL: i.known = 1'b1;
         default: i.known = 1'b0;
      endcase
      return i;
   endfunction

endpackage

/* src/sfd_if.sv */
/*
 Serial link between the flash command decoder and its host.
 Assumes a pull-up on the data-out line: it reads high while undriven.
*/
`timescale 1ns/1ps

interface sfd_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   wire logic miso_line;

   assign miso_line = miso_oe ? miso : 1'b1;

   modport dev (input sck, input cs_n, input mosi, output miso,
      output miso_oe);
   modport host (output sck, output cs_n, output mosi, input miso_line);
endinterface

/* src/sfd_host.sv */
/*
 Host end of the serial flash link with its command FIFO.
 Assumes sfd_dev.sv is compiled first for the synchroniser; the user side
 runs on clk and obeys valid/ready.
*/
`timescale 1ns/1ps
`include "sfd_map.svh"

////////////////////////////////////////////////////////////////////////////
module sfd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = `SFD_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two of at least two");
   end

   wire logic push = in_valid & in_ready;
   wire logic pop = out_valid & out_ready;
   assign in_ready = cnt_reg != DEPTH[AW:0];
   assign out_valid = cnt_reg != '0;
   assign out_data = mem[rd_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_reg + AW'(push);
         rd_reg <= rd_reg + AW'(pop);
         cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module sfd_host #(
   parameter int HALF = `SFD_HALF_DEF,
   parameter int DEPTH = `SFD_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   sfd_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_op,
   input wire logic [23:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_skip_addr,
   input wire logic [7:0] cmd_rd_len,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic idle
);
   localparam int CW = 49;
   sfd_pkg::sfd_host_state_t state_reg;
   logic [7:0] cnt_reg;
   logic [39:0] sh_reg;
   logic [11:0] bits_reg;
   logic [11:0] rd_bits_reg;
   logic [7:0] rx_reg;
   logic sck_reg;
   logic cs_n_reg;
   logic f_valid;
   logic [CW-1:0] f_data;
   logic miso_q;

   if (HALF < `SFD_HALF_MIN || HALF > 255) begin : g_chk
      $error("half period out of range for the link latency");
   end

   wire logic pop = f_valid & (state_reg == sfd_pkg::HST_IDLE);

   sfd_fifo #(.W(CW), .DEPTH(DEPTH)) cmd_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data({cmd_op, cmd_addr, cmd_data, cmd_skip_addr, cmd_rd_len}),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
   );

   sfd_sync #(.W(1), .INIT(1'b1)) miso_sync (
      .clk(clk),
      .rst(rst),
      .d(link.miso_line),
      .q(miso_q)
   );

   wire logic [7:0] f_op = f_data[48:41];
   wire logic [23:0] f_addr = f_data[40:17];
   wire logic [7:0] f_dat = f_data[16:9];
   wire logic f_skip = f_data[8];
   wire logic [7:0] f_rd = f_data[7:0];
   wire sfd_pkg::sfd_op_info_t f_info = sfd_pkg::op_info(f_op);
   wire logic send_addr = f_info.has_addr & ~f_skip;
   wire logic send_extra = f_info.dummy | f_info.has_data;
   wire logic [11:0] rd_bytes = f_info.is_read ? {4'h0, f_rd} : 12'h0;
   wire logic [11:0] tx_bytes = 12'h1 + (send_addr ? 12'h3 : 12'h0)
      + (send_extra ? 12'h1 : 12'h0);
   wire logic [39:0] f_sh = send_addr ? {f_op, f_addr, f_dat}
      : {f_op, f_dat, 24'h0};
   wire logic half_done = cnt_reg == 8'(HALF - 1);
   wire logic [7:0] rx_next = {rx_reg[6:0], miso_q};
   wire logic rx_byte = (bits_reg <= rd_bits_reg) & (bits_reg[2:0] == 3'h1);

   assign link.sck = sck_reg;
   assign link.cs_n = cs_n_reg;
   assign link.mosi = sh_reg[39];
   assign idle = state_reg == sfd_pkg::HST_IDLE;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= sfd_pkg::HST_IDLE;
         cnt_reg <= '0;
         sh_reg <= '0;
         bits_reg <= '0;
         rd_bits_reg <= '0;
         rx_reg <= '0;
         sck_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
      end else begin
         rsp_valid <= 1'b0;
         cnt_reg <= half_done ? 8'h0 : cnt_reg + 8'h1;
         case (state_reg)
            sfd_pkg::HST_IDLE: begin
               cnt_reg <= '0;
               if (f_valid) begin
                  cs_n_reg <= 1'b0;
                  sh_reg <= f_sh;
                  bits_reg <= (tx_bytes + rd_bytes) << 3;
                  rd_bits_reg <= rd_bytes << 3;
                  state_reg <= sfd_pkg::HST_LOW;
               end
            end
            sfd_pkg::HST_LOW: begin
               if (half_done) begin
                  sck_reg <= 1'b1;
                  state_reg <= sfd_pkg::HST_HIGH;
               end
            end
            sfd_pkg::HST_HIGH: begin
               if (half_done) begin
                  sck_reg <= 1'b0;
                  rx_reg <= rx_next;
                  bits_reg <= bits_reg - 12'h1;
                  sh_reg <= {sh_reg[38:0], 1'b0};
                  if (rx_byte) begin
                     rsp_valid <= 1'b1;
                     rsp_data <= rx_next;
                  end
                  state_reg <= (bits_reg == 12'h1) ? sfd_pkg::HST_END
                     : sfd_pkg::HST_LOW;
               end
            end
            sfd_pkg::HST_END: begin
               if (half_done) begin
                  cs_n_reg <= 1'b1;
                  state_reg <= sfd_pkg::HST_GAP;
               end
            end
            sfd_pkg::HST_GAP: begin
               if (half_done) begin
                  state_reg <= sfd_pkg::HST_IDLE;
               end
            end
            default: state_reg <= sfd_pkg::HST_IDLE;
         endcase
      end
   end
endmodule

/* sim/sfd_link_chk.sv */
/*
 Checker for the serial link between the flash decoder and its host end.
 Assumes it sits beside the link interface, on the bench clock and reset.
*/
`timescale 1ns/1ps

module sfd_link_chk #(
   parameter int HALF = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line
);
   logic [7:0] hi_cnt_reg;
   logic [7:0] lo_cnt_reg;
   logic [7:0] bit_cnt_reg;
   logic sck_q_reg;
   logic [7:0] hi_cnt_next;
   logic [7:0] lo_cnt_next;
   logic [7:0] bit_cnt_next;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Phase lengths of the serial clock and rising edges within a frame.
   assign hi_cnt_next = sck ? hi_cnt_reg + 8'h01 : 8'h00;
   assign lo_cnt_next = (sck || cs_n) ? 8'h00 : lo_cnt_reg + 8'h01;
   assign bit_cnt_next = cs_n ? 8'h00 :
      bit_cnt_reg + {7'h00, sck & ~sck_q_reg};

   always_ff @(posedge clk) begin
      if (rst) begin
         hi_cnt_reg <= 8'h00;
         lo_cnt_reg <= 8'h00;
         bit_cnt_reg <= 8'h00;
         sck_q_reg <= 1'b0;
      end else begin
         hi_cnt_reg <= hi_cnt_next;
         lo_cnt_reg <= lo_cnt_next;
         bit_cnt_reg <= bit_cnt_next;
         sck_q_reg <= sck;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_idle_clock_low: assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
   chk_mosi_low_phase: assert property ($changed(mosi) |-> !sck)
      else $error("data in changed while serial clock high");
   chk_high_phase_len: assert property (
      $fell(sck) |-> hi_cnt_reg == 8'(HALF))
      else $error("serial clock high phase length wrong");
   chk_low_phase_len: assert property (
      $rose(sck) |-> lo_cnt_reg == 8'(HALF))
      else $error("serial clock low phase length wrong");
   chk_whole_bytes: assert property (
      $rose(cs_n) |-> bit_cnt_reg[2:0] == 3'h0)
      else $error("frame is not whole bytes");
   chk_deselect_wait: assert property (
      $rose(cs_n) |-> lo_cnt_reg == 8'(HALF))
      else $error("deselect before last bit completed");
   chk_opcode_quiet: assert property (
      $fell(cs_n) |-> ##5 !miso_oe [*8])
      else $error("data out driven during opcode");
   chk_release_out: assert property (
      $rose(cs_n) |-> ##[0:8] (!miso_oe && miso_line))
      else $error("data out still driven after deselect");
endmodule

/* sim/spi_flash_command_decoder_bench.sv */
/*
 Bench joining both ends of the serial flash link, driving the host user
 side and the device's array and status inputs.
 Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/1ps

module spi_flash_command_decoder_bench;
   localparam int HALF = 6;
   logic clk, rst, busy, cmd_valid, cmd_ready, cmd_skip_addr;
   logic op_valid, wel, rsp_valid, idle, sck_q, cs_q, aai_mode;
   logic [5:0] status_hi;
   logic [7:0] rd_data, op_code, op_data, cmd_op, cmd_data, cmd_rd_len;
   logic [7:0] rsp_data;
   logic [23:0] rd_addr, op_addr, cmd_addr;
   logic [39:0] wire_bits;
   logic [7:0] ops[$];
   logic [7:0] rsp[$];
   int nbits, n_mismatch, total_checks;

   sfd_if link();
   sfd_dev u_sfd_dev (.clk(clk), .rst(rst), .link(link.dev), .busy(busy),
      .status_hi(status_hi), .rd_data(rd_data), .rd_addr(rd_addr),
      .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
      .op_data(op_data), .wel(wel), .aai_mode(aai_mode));
   sfd_host #(.HALF(HALF)) u_sfd_host (.clk(clk), .rst(rst),
      .link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_skip_addr(cmd_skip_addr), .cmd_rd_len(cmd_rd_len),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .idle(idle));
   sfd_link_chk #(.HALF(HALF)) u_sfd_link_chk (.clk(clk), .rst(rst),
      .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
      .miso(link.miso), .miso_oe(link.miso_oe),
      .miso_line(link.miso_line));

   // Array contents are a fixed pattern of the address.
   assign rd_data = rd_addr[7:0] ^ 8'h5c;

   ////////////////////////////////////////////////////////////////////////
   // Records executed opcodes, read bytes and the bits of the last frame.
   always @(posedge clk) begin
      if (op_valid === 1'b1) ops.push_back(op_code);
      if (rsp_valid === 1'b1) rsp.push_back(rsp_data);
      if (link.cs_n === 1'b0 && cs_q === 1'b1) nbits = 0;
      if (link.cs_n === 1'b0 && link.sck === 1'b1 && sck_q === 1'b0) begin
         wire_bits = {wire_bits[38:0], link.mosi};
         nbits++;
      end
      sck_q = link.sck;
      cs_q = link.cs_n;
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic push(input logic [7:0] op, input logic [23:0] a,
         input logic [7:0] d, input logic [7:0] n);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_rd_len = n;
      while (cmd_ready !== 1'b1) begin
         @(posedge clk);
         #2;
      end
      @(posedge clk);
      #2;
   endtask

   // Waits for a settled idle host.
   task automatic quiet();
      int run = 0;
      while (run < 24) begin
         @(posedge clk);
         #2;
         run = (idle === 1'b1) ? run + 1 : 0;
      end
   endtask

   task automatic send(input logic [7:0] op, input logic [23:0] a,
         input logic [7:0] d, input logic [7:0] n);
      push(op, a, d, n);
      cmd_valid = 1'b0;
      quiet();
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      logic [7:0] wr_ops[6] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'haf};
      ops = {};
      send(8'h02, 24'h123456, 8'ha5, 8'h00);
      chk(40'(ops.size()), 40'h0);
      send(8'h06, 24'h0, 8'h00, 8'h00);
      chk({39'h0, wel}, 40'h1);
      send(8'h02, 24'h123456, 8'ha5, 8'h00);
      chk({op_code, op_addr, op_data}, 40'h02123456a5);
      chk(wire_bits, 40'h02123456a5);
      chk(40'(nbits), 40'd40);
      send(8'h04, 24'h0, 8'h00, 8'h00);
      chk({39'h0, wel}, 40'h0);
      foreach (wr_ops[i]) begin
         send(8'h06, 24'h0, 8'h00, 8'h00);
         send(wr_ops[i], 24'h001000, 8'h3e, 8'h00);
         chk({32'h0, op_code}, {32'h0, wr_ops[i]});
      end
      cmd_skip_addr = 1'b1;
      send(8'haf, 24'h0, 8'h77, 8'h00);
      cmd_skip_addr = 1'b0;
      chk({7'h0, aai_mode, op_addr, op_data}, 40'h0100100177);
      send(8'h04, 24'h0, 8'h00, 8'h00);
      $display("write opcodes done");
   endtask

   task automatic t_status();
      rsp = {};
      status_hi = 6'h2b;
      send(8'h06, 24'h0, 8'h00, 8'h00);
      send(8'h05, 24'h0, 8'h00, 8'h02);
      busy = 1'b1;
      send(8'h05, 24'h0, 8'h00, 8'h01);
      busy = 1'b0;
      chk({16'h0, rsp[0], rsp[1], rsp[2]}, 40'haeaeaf);
      send(8'h04, 24'h0, 8'h00, 8'h00);
      $display("status read done");
   endtask

   task automatic t_read();
      rsp = {};
      send(8'h03, 24'h0000fe, 8'h00, 8'h03);
      send(8'h0b, 24'h0000fe, 8'hff, 8'h03);
      chk(40'(rsp.size()), 40'd6);
      chk({16'h0, rsp[0], rsp[1], rsp[2]}, 40'ha2a35c);
      chk({16'h0, rsp[3], rsp[4], rsp[5]}, 40'ha2a35c);
      $display("array reads done");
   endtask

   task automatic t_id();
      rsp = {};
      send(8'h90, 24'h000000, 8'h00, 8'h02);
      send(8'hab, 24'h000001, 8'h00, 8'h01);
      chk({16'h0, rsp[0], rsp[1], rsp[2]}, 40'h5a3c3c);
      $display("identification done");
   endtask

   task automatic t_unlock();
      int n = 0;
      ops = {};
      send(8'h50, 24'h0, 8'h00, 8'h00);
      send(8'h01, 24'h0, 8'h8c, 8'h00);
      send(8'h01, 24'h0, 8'h8d, 8'h00);
      foreach (ops[i]) if (ops[i] === 8'h01) n++;
      chk(40'(n), 40'd1);
      chk({32'h0, op_data}, 40'h8c);
      $display("status write done");
   endtask

   task automatic t_fifo();
      logic full = 1'b0;
      ops = {};
      for (int i = 0; i < 12; i++) begin
         if (cmd_ready !== 1'b1) full = 1'b1;
         push(8'h04, 24'h0, 8'h00, 8'h00);
      end
      cmd_valid = 1'b0;
      quiet();
      chk({39'h0, full}, 40'h1);
      chk(40'(ops.size()), 40'd12);
      $display("queue fill done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      busy = 1'b0;
      status_hi = 6'h00;
      cmd_valid = 1'b0;
      cmd_skip_addr = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      t_write();
      t_status();
      t_read();
      t_id();
      t_unlock();
      t_fifo();
      finish_test();
   end

   // About nine and a half times the expected run.
   initial begin
      #2400000;
      n_mismatch++;
      finish_test();
   end
endmodule
